// ===== hw/tscf_pkg.sv
// Constants, register map and types for the touch sensor configuration and filter block
package tscf_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_SENSORS = 16; // Sensor inputs zero to fifteen
  localparam int IDX_W = 4; // Sensor index width
  localparam int RAW_W = 16; // Raw count width
  localparam int FRAC_W = 8; // Fraction bits kept in the recursive average
  localparam int ACC_W = RAW_W + FRAC_W; // Average accumulator width
  localparam int MEM_W = ACC_W + 2 * RAW_W; // History word: average, older, newer
  localparam int ADDR_W = 8; // APB byte address width

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00; // Filter and mode control
  localparam logic [ADDR_W-1:0] ADDR_SENS_SENSOR = 8'h04; // Two bits per sensor
  localparam logic [ADDR_W-1:0] ADDR_SENS_SLIDER = 8'h08; // Two bits per slider group
  localparam logic [ADDR_W-1:0] ADDR_SENSOR_KIND = 8'h0c; // Two bits per sensor
  localparam logic [ADDR_W-1:0] ADDR_FSS_EN = 8'h10; // Flanking suppression per button
  localparam logic [ADDR_W-1:0] ADDR_PROX_RES = 8'h14; // Proximity resolutions
  localparam logic [ADDR_W-1:0] ADDR_SLIDER_RES = 8'h18; // Slider resolutions
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1c; // Reported buttons, read only
  localparam logic [ADDR_W-1:0] ADDR_LAST_FILT = 8'h20; // Last filtered sample, read only

  ////////////////////////////////////////////////////////////////////////////////
  // Control fields
  localparam int CTRL_MED_BIT = 0; // Median stage enable
  localparam int CTRL_IIR_BIT = 1; // Recursive low-pass enable
  localparam int CTRL_NOISE_BIT = 2; // Noise immunity mode
  localparam int CTRL_AUTO_BIT = 3; // Automatic thresholding
  localparam int CTRL_COMBINE_BIT = 4; // Both slider groups form one slider
  localparam int CTRL_SHIFT_LSB = 8; // Low-pass weight shift
  localparam int SHIFT_W = 3; // Shift width
  localparam logic [31:0] CTRL_RST = 32'h0000_0208; // Auto threshold on, shift two
  localparam logic [31:0] CTRL_MASK = 32'h0000_071f; // Implemented control bits

  ////////////////////////////////////////////////////////////////////////////////
  // Sensitivity codes, 100 fF steps
  localparam logic [1:0] SENS_100FF = 2'h0; // Strongest signal
  localparam logic [1:0] SENS_200FF = 2'h1;
  localparam logic [1:0] SENS_300FF = 2'h2;
  localparam logic [1:0] SENS_400FF = 2'h3; // Weakest signal
  localparam logic [31:0] SENS_SENSOR_RST = 32'h0000_0000; // All 100 fF
  localparam logic [3:0] SENS_SLIDER_RST = 4'h0; // Both groups 100 fF

  ////////////////////////////////////////////////////////////////////////////////
  // Resolution limits and reset values
  localparam logic [4:0] PROX_RES_MIN = 5'h0c; // 12 bits
  localparam logic [4:0] PROX_RES_MAX = 5'h10; // 16 bits
  localparam logic [4:0] PROX_RES_RST = 5'h0c;
  localparam int PROX1_LSB = 8; // Second proximity field position
  localparam logic [7:0] SLD_RES_MIN = 8'h01; // 1 position
  localparam logic [7:0] SLD_RES_MAX = 8'hfe; // 254 positions
  localparam logic [7:0] SLD_RES_RST = 8'h64;
  localparam int SLD2_LSB = 8; // Second slider group field position
  localparam logic [31:0] KIND_RST = 32'h0000_0000; // All buttons
  localparam logic [15:0] FSS_RST = 16'h0000; // Suppression off

  ////////////////////////////////////////////////////////////////////////////////
  // Noise immunity coverage per variant
  localparam logic [15:0] NOISE_MASK_GENERAL = 16'hffff;
  localparam logic [15:0] NOISE_MASK_SLIDER = 16'h003f; // Inputs zero to five
  localparam logic [15:0] NOISE_MASK_SIXTEEN = 16'h03ff; // Inputs zero to nine
  localparam logic [1:0] FILL_FULL = 2'h2; // Two earlier samples held

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {KIND_BUTTON, KIND_SLIDER, KIND_GUARD, KIND_PROX} tscf_kind_type;
  typedef enum logic [1:0] {VAR_GENERAL, VAR_SLIDER, VAR_SIXTEEN, VAR_FIXED} tscf_variant_type;

endpackage : tscf_pkg

// ===== hw/tscf_hist_mem.sv
// Per-sensor sample history store with registered read data
`timescale 1ns/10ps
module tscf_hist_mem (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Read port
  input wire logic rd_en,
  input wire logic [tscf_pkg::IDX_W-1:0] rd_addr,
  output logic [tscf_pkg::MEM_W-1:0] rd_data_q,
  // Write port
  input wire logic wr_en,
  input wire logic [tscf_pkg::IDX_W-1:0] wr_addr,
  input wire logic [tscf_pkg::MEM_W-1:0] wr_data
);

  // Storage, no reset; the fill counters outside guard stale words
  logic [tscf_pkg::MEM_W-1:0] mem_q [tscf_pkg::NUM_SENSORS];

  ////////////////////////////////////////////////////////////////////////////////
  // Write
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered read; a same-cycle write is not bypassed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule : tscf_hist_mem

// ===== hw/tscf_top.sv
// Touch sensor configuration, flanking suppression and raw-count filter chain
//
// Summary of operation
// R1: Four sensitivity codes, 100 to 400 fF
// R2: Sensitivity per button, guard, slider; none proximity
// R3: Proximity resolution 12 to 16 bits
// R4: Slider resolution 1 to 254 per group
// R5: Two slider groups; combined uses one resolution
// R6: Slider variant: noise mode only inputs 0-5
// R7: Sixteen variant: host disables noise mode sometimes
// R8: Host keeps noise mode off with buzzer
// R9: Suppression reports at most one button ON
// R10: First touched button keeps ON while held
// R11: Simultaneous touches: lowest index wins
// R12: Suppression enable per button, buttons only
// R13: Median and IIR skip proximity sensors
// R14: Median of three latest samples per sensor
// R15: IIR is a recursive low-pass
// R16: Median stage feeds the IIR stage
// R17: Host disables filters with noise mode
// R18: Host prefers manual threshold with median
// R19: Fixed variant: both filters always on
// R20: Fixed variant: sensitivity fixed 100 fF
// R21: Noise mode forces automatic threshold off
// R22: IIR weight power of two; window fills first
// R23: Enables take effect at next scan; the auto threshold and combine bits apply at once
`timescale 1ns/10ps
module tscf_top #(
  parameter tscf_pkg::tscf_variant_type VARIANT = tscf_pkg::VAR_GENERAL
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tscf_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Scan framing and touch status from detection logic
  input wire logic scan_start,
  input wire logic scan_done,
  input wire logic [tscf_pkg::NUM_SENSORS-1:0] touch_status,
  // Raw counts from the sensing front end
  input wire logic raw_valid,
  input wire logic [tscf_pkg::IDX_W-1:0] raw_index,
  input wire logic [tscf_pkg::RAW_W-1:0] raw_count,
  // Filtered counts
  output logic filt_valid_q,
  output logic [tscf_pkg::IDX_W-1:0] filt_index_q,
  output logic [tscf_pkg::RAW_W-1:0] filt_count_q,
  // Reported buttons and effective configuration
  output logic [tscf_pkg::NUM_SENSORS-1:0] button_on_q,
  output logic [2*tscf_pkg::NUM_SENSORS-1:0] sens_code_q,
  output logic [3:0] slider_sens_q,
  output logic [9:0] prox_res_q,
  output logic [15:0] slider_res_q,
  output logic [tscf_pkg::NUM_SENSORS-1:0] noise_mask_q,
  output logic auto_thr_q
);

  localparam logic IS_FIXED = (VARIANT == tscf_pkg::VAR_FIXED); // Fixed-function build
  localparam logic [15:0] NOISE_MASK = (VARIANT == tscf_pkg::VAR_SLIDER) ?
      tscf_pkg::NOISE_MASK_SLIDER : (VARIANT == tscf_pkg::VAR_SIXTEEN) ?
      tscf_pkg::NOISE_MASK_SIXTEEN : tscf_pkg::NOISE_MASK_GENERAL;

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [31:0] ctrl_q; // Control word
  logic [31:0] sens_q; // Sensor sensitivity codes
  logic [3:0] sens_sld_q; // Slider group sensitivity codes
  logic [31:0] kind_q; // Sensor kinds
  logic [15:0] fss_q; // Suppression enables
  logic [4:0] prox0_q, prox1_q; // Proximity resolutions
  logic [7:0] sld1_q, sld2_q; // Slider resolutions
  // Copies latched at scan start
  logic med_act_q, iir_act_q, noise_act_q;
  logic [tscf_pkg::SHIFT_W-1:0] shift_act_q;
  logic [15:0] fss_act_q;
  logic [31:0] kind_act_q;
  // Suppression state
  logic owner_v_q;
  logic [tscf_pkg::IDX_W-1:0] owner_q;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup = psel && !penable;
  wire wr_fire = psel && penable && pready_q && pwrite;
  wire hit_ctrl = (paddr == tscf_pkg::ADDR_CTRL);
  wire hit_sens = (paddr == tscf_pkg::ADDR_SENS_SENSOR);
  wire hit_sld = (paddr == tscf_pkg::ADDR_SENS_SLIDER);
  wire hit_kind = (paddr == tscf_pkg::ADDR_SENSOR_KIND);
  wire hit_fss = (paddr == tscf_pkg::ADDR_FSS_EN);
  wire hit_prox = (paddr == tscf_pkg::ADDR_PROX_RES);
  wire hit_sres = (paddr == tscf_pkg::ADDR_SLIDER_RES);
  wire hit_stat = (paddr == tscf_pkg::ADDR_STATUS);
  wire hit_last = (paddr == tscf_pkg::ADDR_LAST_FILT);
  wire hit_any = hit_ctrl || hit_sens || hit_sld || hit_kind || hit_fss || hit_prox ||
      hit_sres || hit_stat || hit_last;
  // Range checks; an out-of-range field keeps its old value
  wire [4:0] wp0 = pwdata[4:0];
  wire [4:0] wp1 = pwdata[tscf_pkg::PROX1_LSB +: 5];
  wire [7:0] ws1 = pwdata[7:0];
  wire [7:0] ws2 = pwdata[tscf_pkg::SLD2_LSB +: 8];
  wire p0_ok = (wp0 >= tscf_pkg::PROX_RES_MIN) && (wp0 <= tscf_pkg::PROX_RES_MAX); // R3
  wire p1_ok = (wp1 >= tscf_pkg::PROX_RES_MIN) && (wp1 <= tscf_pkg::PROX_RES_MAX); // R3
  wire s1_ok = (ws1 >= tscf_pkg::SLD_RES_MIN) && (ws1 <= tscf_pkg::SLD_RES_MAX); // R4
  wire s2_ok = (ws2 >= tscf_pkg::SLD_RES_MIN) && (ws2 <= tscf_pkg::SLD_RES_MAX); // R4
  // Read mux
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
      hit_sens ? sens_q :
      hit_sld ? {28'h0, sens_sld_q} :
      hit_kind ? kind_q :
      hit_fss ? {16'h0, fss_q} :
      hit_prox ? {19'h0, prox1_q, 3'h0, prox0_q} :
      hit_sres ? {16'h0, sld2_q, sld1_q} :
      hit_stat ? {11'h0, owner_v_q, owner_q, button_on_q} :
      hit_last ? {12'h0, filt_index_q, filt_count_q} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer: one access cycle, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !hit_any;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tscf_pkg::CTRL_RST;
      sens_q <= tscf_pkg::SENS_SENSOR_RST;
      sens_sld_q <= tscf_pkg::SENS_SLIDER_RST;
      kind_q <= tscf_pkg::KIND_RST;
      fss_q <= tscf_pkg::FSS_RST;
      prox0_q <= tscf_pkg::PROX_RES_RST;
      prox1_q <= tscf_pkg::PROX_RES_RST;
      sld1_q <= tscf_pkg::SLD_RES_RST;
      sld2_q <= tscf_pkg::SLD_RES_RST;
    end else if (wr_fire) begin
      if (hit_ctrl) ctrl_q <= pwdata & tscf_pkg::CTRL_MASK;
      if (hit_sens) sens_q <= pwdata; // R2
      if (hit_sld) sens_sld_q <= pwdata[3:0]; // R2
      if (hit_kind) kind_q <= pwdata;
      if (hit_fss) fss_q <= pwdata[15:0]; // R12
      if (hit_prox && p0_ok) prox0_q <= wp0; // R3
      if (hit_prox && p1_ok) prox1_q <= wp1; // R3
      if (hit_sres && s1_ok) sld1_q <= ws1; // R4
      if (hit_sres && s2_ok) sld2_q <= ws2; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scan-boundary latch, so filters, noise mode and suppression never see a half-changed setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      med_act_q <= IS_FIXED;
      iir_act_q <= IS_FIXED;
      noise_act_q <= 1'b0;
      shift_act_q <= '0;
      fss_act_q <= '0;
      kind_act_q <= '0;
    end else if (scan_start) begin // R23
      med_act_q <= IS_FIXED || ctrl_q[tscf_pkg::CTRL_MED_BIT]; // R19
      iir_act_q <= IS_FIXED || ctrl_q[tscf_pkg::CTRL_IIR_BIT]; // R19
      noise_act_q <= !IS_FIXED && ctrl_q[tscf_pkg::CTRL_NOISE_BIT];
      shift_act_q <= ctrl_q[tscf_pkg::CTRL_SHIFT_LSB +: tscf_pkg::SHIFT_W];
      fss_act_q <= IS_FIXED ? 16'h0 : fss_q;
      kind_act_q <= kind_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flanking suppression: pick the owner among touched enabled buttons
  logic [15:0] btn_mask; // Sensors of button kind as latched at scan start
  logic [15:0] prox_mask; // Sensors currently of proximity kind
  logic [tscf_pkg::IDX_W-1:0] lowest_idx; // Lowest touched suppressed button
  logic [31:0] sens_eff; // Effective sensitivity codes
  always_comb begin
    btn_mask = '0;
    prox_mask = '0;
    lowest_idx = '0;
    sens_eff = '0;
    for (int i = 0; i < tscf_pkg::NUM_SENSORS; i++) begin
      btn_mask[i] = (kind_act_q[2*i +: 2] == tscf_pkg::KIND_BUTTON); // R12
      prox_mask[i] = (kind_q[2*i +: 2] == tscf_pkg::KIND_PROX);
      // Proximity sensors carry no code; fixed build stays at 100 fF
      sens_eff[2*i +: 2] = (IS_FIXED || prox_mask[i]) ? tscf_pkg::SENS_100FF :
          sens_q[2*i +: 2]; // R1 R2 R20
    end
    for (int i = tscf_pkg::NUM_SENSORS - 1; i >= 0; i--) begin
      if (touch_status[i] && fss_act_q[i] && btn_mask[i]) begin
        lowest_idx = tscf_pkg::IDX_W'(i); // R11
      end
    end
  end
  wire [15:0] fss_grp = fss_act_q & btn_mask; // Buttons under suppression
  wire [15:0] fss_touch = touch_status & fss_grp; // Touched among them
  wire owner_keep = owner_v_q && fss_touch[owner_q]; // R10
  wire [tscf_pkg::IDX_W-1:0] owner_d = owner_keep ? owner_q : lowest_idx; // R10 R11
  wire owner_v_d = owner_keep || (|fss_touch);
  wire [15:0] owner_hot = owner_v_d ? (16'h0001 << owner_d) : 16'h0000;
  wire [15:0] button_on_d = (touch_status & ~fss_grp) | owner_hot; // R9

  // Suppression state and reported buttons, updated once per scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner_v_q <= 1'b0;
      owner_q <= '0;
      button_on_q <= '0;
    end else if (scan_done) begin
      owner_v_q <= owner_v_d;
      owner_q <= owner_d;
      button_on_q <= button_on_d; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective configuration outputs
  wire combine = ctrl_q[tscf_pkg::CTRL_COMBINE_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_code_q <= '0;
      slider_sens_q <= '0;
      prox_res_q <= {tscf_pkg::PROX_RES_RST, tscf_pkg::PROX_RES_RST};
      slider_res_q <= {tscf_pkg::SLD_RES_RST, tscf_pkg::SLD_RES_RST};
      noise_mask_q <= '0;
      auto_thr_q <= 1'b0;
    end else begin
      sens_code_q <= sens_eff;
      slider_sens_q <= IS_FIXED ? 4'h0 :
          (combine ? {sens_sld_q[1:0], sens_sld_q[1:0]} : sens_sld_q); // R5
      prox_res_q <= {prox1_q, prox0_q}; // R3
      slider_res_q <= combine ? {sld1_q, sld1_q} : {sld2_q, sld1_q}; // R5
      noise_mask_q <= noise_act_q ? NOISE_MASK : 16'h0; // R6
      auto_thr_q <= IS_FIXED || (ctrl_q[tscf_pkg::CTRL_AUTO_BIT] && !noise_act_q); // R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Filter pipeline, stage one: capture sample, read history
  logic s1_v_q;
  logic [tscf_pkg::IDX_W-1:0] s1_idx_q;
  logic [tscf_pkg::RAW_W-1:0] s1_raw_q;
  logic [1:0] fill_q [tscf_pkg::NUM_SENSORS]; // Earlier samples held per sensor
  logic [tscf_pkg::MEM_W-1:0] hist_rd;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_v_q <= 1'b0;
      s1_idx_q <= '0;
      s1_raw_q <= '0;
    end else begin
      s1_v_q <= raw_valid;
      s1_idx_q <= raw_index;
      s1_raw_q <= raw_count;
    end
  end

  // Stage two: median of three, then the recursive average
  wire [tscf_pkg::RAW_W-1:0] h_new = hist_rd[tscf_pkg::RAW_W-1:0];
  wire [tscf_pkg::RAW_W-1:0] h_old = hist_rd[2*tscf_pkg::RAW_W-1:tscf_pkg::RAW_W];
  wire [tscf_pkg::ACC_W-1:0] h_acc = hist_rd[tscf_pkg::MEM_W-1:2*tscf_pkg::RAW_W];
  wire [1:0] s1_fill = fill_q[s1_idx_q];
  wire filterable = (kind_act_q[2*s1_idx_q +: 2] != tscf_pkg::KIND_PROX); // R13
  wire [tscf_pkg::RAW_W-1:0] mn_ab = (s1_raw_q < h_new) ? s1_raw_q : h_new;
  wire [tscf_pkg::RAW_W-1:0] mx_ab = (s1_raw_q < h_new) ? h_new : s1_raw_q;
  wire [tscf_pkg::RAW_W-1:0] mn_c = (mx_ab < h_old) ? mx_ab : h_old;
  wire [tscf_pkg::RAW_W-1:0] med3 = (mn_ab > mn_c) ? mn_ab : mn_c; // R14
  // Window passes raw counts until two earlier samples exist
  wire med_use = med_act_q && filterable && (s1_fill == tscf_pkg::FILL_FULL); // R22
  wire [tscf_pkg::RAW_W-1:0] med_out = med_use ? med3 : s1_raw_q; // R14
  wire [tscf_pkg::ACC_W-1:0] acc_in = {med_out, {tscf_pkg::FRAC_W{1'b0}}}; // R16
  wire signed [tscf_pkg::ACC_W:0] acc_diff = $signed({1'b0, acc_in}) - $signed({1'b0, h_acc});
  wire signed [tscf_pkg::ACC_W:0] acc_step = acc_diff >>> shift_act_q; // R22
  wire signed [tscf_pkg::ACC_W:0] acc_sum = $signed({1'b0, h_acc}) + acc_step; // R15
  wire [tscf_pkg::ACC_W-1:0] acc_next = (s1_fill == 2'h0) ? acc_in :
      acc_sum[tscf_pkg::ACC_W-1:0]; // R22
  wire [tscf_pkg::RAW_W-1:0] iir_out = acc_next[tscf_pkg::ACC_W-1:tscf_pkg::FRAC_W];
  wire [tscf_pkg::RAW_W-1:0] filt_d = (iir_act_q && filterable) ? iir_out : med_out; // R16
  // History keeps tracking while filters are off, so enabling is seamless
  wire [tscf_pkg::MEM_W-1:0] hist_wr = {acc_next, h_new, s1_raw_q};

  tscf_hist_mem u_hist (
    .pclk(pclk),
    .presetn(presetn),
    .rd_en(raw_valid),
    .rd_addr(raw_index),
    .rd_data_q(hist_rd),
    .wr_en(s1_v_q),
    .wr_addr(s1_idx_q),
    .wr_data(hist_wr)
  );

  // Fill counters and filtered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < tscf_pkg::NUM_SENSORS; i++) fill_q[i] <= 2'h0;
      filt_valid_q <= 1'b0;
      filt_index_q <= '0;
      filt_count_q <= '0;
    end else begin
      if (s1_v_q && s1_fill != tscf_pkg::FILL_FULL) fill_q[s1_idx_q] <= s1_fill + 2'h1; // R22
      filt_valid_q <= s1_v_q;
      filt_index_q <= s1_idx_q;
      filt_count_q <= filt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_fss_single: assert property (@(posedge pclk) disable iff (!presetn) // R9
      $onehot0(button_on_q & fss_grp)) else $error("More than one suppressed button ON");
  a_owner_held: assert property (@(posedge pclk) disable iff (!presetn) // R10
      scan_done && owner_keep |=> owner_v_q && owner_q == $past(owner_q))
      else $error("Held owner lost ON report");
  a_lowest_win: assert property (@(posedge pclk) disable iff (!presetn) // R11
      scan_done && !owner_keep && (|fss_touch) |=> owner_q == $past(lowest_idx)
      && button_on_q[owner_q]) else $error("Lowest touched button not chosen");
  a_median_path: assert property (@(posedge pclk) disable iff (!presetn) // R14
      s1_v_q && med_use && !iir_act_q |=> filt_valid_q && filt_count_q == $past(med3))
      else $error("Median output wrong");
  a_prox_bypass: assert property (@(posedge pclk) disable iff (!presetn) // R13
      s1_v_q && !filterable |=> filt_count_q == $past(s1_raw_q))
      else $error("Proximity sample was filtered");
  a_iir_bounded: assert property (@(posedge pclk) disable iff (!presetn) // R15
      s1_v_q && s1_fill != 2'h0 && shift_act_q != 0 |->
      ((acc_next >= h_acc && acc_next <= acc_in) || (acc_next <= h_acc && acc_next >= acc_in)))
      else $error("Low-pass overshoots its input");
  a_fixed_filters: assert property (@(posedge pclk) disable iff (!presetn) // R19
      IS_FIXED |-> med_act_q && iir_act_q) else $error("Fixed build filter off");
  a_fixed_sens: assert property (@(posedge pclk) disable iff (!presetn) // R20
      IS_FIXED |-> sens_code_q == 32'h0) else $error("Fixed build sensitivity not 100 fF");
  a_res_ranges: assert property (@(posedge pclk) disable iff (!presetn) // R3 R4
      prox0_q >= tscf_pkg::PROX_RES_MIN && prox0_q <= tscf_pkg::PROX_RES_MAX &&
      sld1_q >= tscf_pkg::SLD_RES_MIN && sld1_q <= tscf_pkg::SLD_RES_MAX)
      else $error("Resolution out of range");
  a_noise_auto: assert property (@(posedge pclk) disable iff (!presetn) // R21
      noise_act_q && !IS_FIXED |=> !auto_thr_q) else $error("Auto threshold left on");
  a_noise_cover: assert property (@(posedge pclk) disable iff (!presetn) // R6
      (VARIANT == tscf_pkg::VAR_SLIDER) |-> noise_mask_q[15:6] == 10'h0)
      else $error("Noise mode reaches slider inputs");
  a_scan_hold: assert property (@(posedge pclk) disable iff (!presetn) // R23
      !scan_start |=> med_act_q == $past(med_act_q) && fss_act_q == $past(fss_act_q))
      else $error("Enable changed inside a scan");
  c_owner_kept: cover property (@(posedge pclk) disable iff (!presetn)
      scan_done && owner_keep && fss_touch != (16'h0001 << owner_q));
  c_median_iir: cover property (@(posedge pclk) disable iff (!presetn)
      s1_v_q && med_use && iir_act_q);
  c_bus_error: cover property (@(posedge pclk) disable iff (!presetn) pslverr_q);

endmodule : tscf_top

// ===== sim/tscf_front_model.sv
// Sensing front end and detection model: scan framing, touch levels, raw samples
`timescale 1ns/10ps
module tscf_front_model (
  // Clock
  input wire logic pclk,
  // Scan framing
  output logic scan_start,
  output logic scan_done,
  output logic [15:0] touch_status,
  // Raw stream
  output logic raw_valid,
  output logic [3:0] raw_index,
  output logic [15:0] raw_count
);
  // Idle values at time zero
  initial begin
    {scan_start, scan_done, raw_valid, raw_index, raw_count, touch_status} = '0;
  end
  // One scan: start pulse, then done pulse carrying the touch levels
  task automatic scan(input logic [15:0] t);
    @(posedge pclk) scan_start <= 1'b1;
    @(posedge pclk) scan_start <= 1'b0;
    scan_done <= 1'b1;
    touch_status <= t;
    @(posedge pclk) scan_done <= 1'b0;
    touch_status <= ~t; // Stale levels are not held after the scan
  endtask : scan
  // One raw sample; count inverted after, so a late read never matches
  task automatic sample(input logic [3:0] i, input logic [15:0] c);
    @(posedge pclk) raw_valid <= 1'b1;
    raw_index <= i;
    raw_count <= c;
    @(posedge pclk) raw_valid <= 1'b0;
    raw_count <= ~c;
  endtask : sample
endmodule : tscf_front_model

// ===== sim/tscf_top_tb_top.sv
// Self-checking bench for the touch configuration and filter block
`timescale 1ns/10ps
module tscf_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata_q, rd;
  logic pready_q, pslverr_q, scan_start, scan_done, raw_valid, filt_valid_q, auto_thr_q;
  logic [15:0] touch_status, raw_count, filt_count_q, button_on_q, noise_mask_q, slider_res_q;
  logic [3:0] raw_index, filt_index_q, slider_sens_q;
  logic [9:0] prox_res_q;
  logic [31:0] sens_code_q;
  int fail_count = 0, checks = 0;
  always #5 pclk = ~pclk;
  tscf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .scan_start, .scan_done, .touch_status, .raw_valid, .raw_index,
    .raw_count, .filt_valid_q, .filt_index_q, .filt_count_q, .button_on_q, .sens_code_q,
    .slider_sens_q, .prox_res_q, .slider_res_q, .noise_mask_q, .auto_thr_q);
  tscf_front_model fe (.pclk, .scan_start, .scan_done, .touch_status, .raw_valid, .raw_index,
    .raw_count);
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    // Request held until the edge at which pready is seen high
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (pready_q !== 1'b1) chk("pready", 1, pready_q);
    rd = prdata_q;
    er = pslverr_q;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Send one sample and compare the filtered count two cycles later
  task automatic filt(input logic [3:0] i, input logic [15:0] c, input logic [15:0] e);
    fe.sample(i, c);
    // Output stands for one cycle only, look mid-cycle while it is there
    @(posedge pclk);
    @(negedge pclk) chk("filt_valid", 1, filt_valid_q);
    chk("filt_count", e, filt_count_q);
    chk("filt_index", i, filt_index_q);
  endtask : filt
  // Verdict, single exit point
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Watchdog, far beyond the hundred-odd cycles the tests need
  initial begin
    #200000 fail_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0); chk("ctrl", 32'h0000_0208, rd);
    apb(1, 8'h14, 32'h0000_1011); apb(0, 8'h14, 0); chk("prox_res", 32'h0000_100c, rd);
    chk("prox_res_out", 10'h20c, prox_res_q);
    apb(1, 8'h18, 32'h0000_ff00); apb(0, 8'h18, 0); chk("sld_res", 32'h0000_6464, rd);
    apb(1, 8'h18, 32'h0000_0a05);
    apb(1, 8'h08, 32'h0000_000e);
    apb(1, 8'h04, 32'hffff_ffff);
    apb(1, 8'h0c, 32'h0000_0c00);
    apb(1, 8'h00, 32'h0000_0010);
    apb(0, 8'h0c, 0);
    chk("kind", 32'h0000_0c00, rd);
    chk("sld_res_out", 16'h0505, slider_res_q);
    chk("sld_sens", 4'ha, slider_sens_q);
    chk("sens_code", 32'hffff_f3ff, sens_code_q);
    apb(0, 8'h40, 0); chk("unmapped", 1, er);
    $display("test registers done");
    apb(1, 8'h00, 32'h0000_0001); fe.scan(0);
    filt(2, 10, 10); filt(2, 12, 12); filt(2, 200, 12);
    apb(1, 8'h00, 32'h0000_0102); fe.scan(0);
    filt(3, 0, 0); filt(3, 100, 50);
    apb(1, 8'h00, 32'h0000_0103); fe.scan(0);
    filt(4, 0, 0); filt(4, 0, 0); filt(4, 200, 0);
    filt(5, 0, 0); filt(5, 100, 100);
    $display("test filters done");
    apb(1, 8'h10, 32'h0000_000f);
    fe.scan(16'h0006); #1 chk("button_on", 16'h0002, button_on_q);
    fe.scan(16'h0007); #1 chk("button_on", 16'h0002, button_on_q);
    fe.scan(16'h0105); #1 chk("button_on", 16'h0101, button_on_q);
    $display("test suppression done");
    apb(1, 8'h00, 32'h0000_000c); fe.scan(0);
    #1 chk("auto_thr", 0, auto_thr_q);
    chk("noise_mask", 16'hffff, noise_mask_q);
    $display("test noise mode done");
    stop_test();
  end
endmodule : tscf_top_tb_top
